// [rtl/tad_alu_slice.sv]
module tad_alu_slice (
  input logic [3:0] operand_a,
  input logic [3:0] operand_b,
  input logic [3:0] function_select,
  input logic logic_mode,
  input logic carry_in,
  output logic [3:0] result,
  output logic slice_carry_output,
  output logic group_generate,
  output logic group_propagate,
  output logic all_ones
);

  logic [3:0] or_term;
  logic [3:0] and_term;
  logic [4:0] carry;

  // ----------------------------------------------------------------
  // per-bit terms: or_term propagates, and_term generates
  // ----------------------------------------------------------------
  always_comb
  begin
    or_term = operand_a | (operand_b & {4{function_select[0]}}) | (~operand_b & {4{function_select[1]}});
    and_term = (operand_a & ~operand_b & {4{function_select[2]}}) | (operand_a & operand_b & {4{function_select[3]}});
  end

  // internal ripple inside the slice
  assign carry[0] = carry_in;
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_bit
      assign carry[i + 1] = and_term[i] | (or_term[i] & carry[i]);
    end
  endgenerate

  // logic mode ignores the carry chain entirely
  assign result = logic_mode ? ~(or_term ^ and_term) : (or_term ^ and_term ^ carry[3:0]);
  assign slice_carry_output = carry[4];
  // group terms let a lookahead unit skip the ripple
  assign group_generate = and_term[3] | (or_term[3] & and_term[2]) | (&or_term[3:2] & and_term[1])
    | (&or_term[3:1] & and_term[0]); // [RULE2]
  assign group_propagate = &or_term; // [RULE2]
  // high whenever every function output is high, for any operation
  assign all_ones = &result; // [RULE9]

endmodule : tad_alu_slice

// [rtl/tad_datapath.sv]
// Functional notes
// [RULE1] ripple mode: each slice carry-in comes from the lower slice carry-out.
// [RULE2] every slice produces group generate and group propagate.
// [RULE3] lookahead takes four gen/prop pairs plus carry, gives three carries, next pair.
// [RULE4] block lookahead splits word into 16-bit blocks, ripple between blocks.
// [RULE5] one lookahead unit serves four slices, full lookahead over 16 bits.
// [RULE6] 20 or 24 bits: one lookahead unit, extra slices ripple.
// [RULE7] 28 or 32 bits: two 16-bit lookahead blocks, ripple lower to upper.
// [RULE8] third lookahead level only above 32 bits.
// [RULE9] equality flag high whenever all result bits are high, any operation.
// [RULE10] equality flag: zero operand on pass, same on xor, complementary on equivalence. Code: complementary on xor, same on equivalence.
// [RULE11] subtract carry-out gives unsigned magnitude, sense flips with operand polarity.
// [RULE12] controller ties select bits 0 and 3 together, bits 1 and 2 low.
// [RULE13] single-address variant: registers A, B, C; C holds multiplicand or divisor.
// [RULE14] three-address variant: eight registers, two sources, one destination.
// [RULE15] read any two registers, operate, write any register.
// [RULE16] two consecutive registers act as one double-length register.
// [RULE17] 2-bit loop code: LL new data, HL pass, LH left, HH right.
// [RULE18] destination captures on the clock edge; source reads combinational.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`include "tad_regs.svh"

module tad_datapath (
  input logic sys_clk,
  input logic srst,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [`TAD_ADDR_BITS-1:0] s_axi_awaddr,
  input logic [2:0] s_axi_awprot,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  input logic [`TAD_ADDR_BITS-1:0] s_axi_araddr,
  input logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  localparam int NUM_SLICES = `TAD_NUM_SLICES;
  localparam int PER_BLOCK = `TAD_SLICES_PER_BLOCK;
  // two 16-bit blocks for a 32-bit word; no third level at this width
  localparam int NUM_BLOCKS = `TAD_WORD_BITS / `TAD_BLOCK_BITS;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  tad_pkg::tad_state_type state;
  logic [31:0] cmd_word;
  logic cfg_lookahead;
  logic [31:0] new_data;
  logic [3:0] view_sel;
  logic [31:0] result_word;
  logic flag_equal;
  logic flag_carry;
  logic flag_gen;
  logic flag_prop;
  logic [31:0] reg_file [`TAD_NUM_REGS];
  logic [31:0] work_a;
  logic [31:0] work_b;
  logic [31:0] work_c;

  logic aw_got;
  logic [`TAD_ADDR_BITS-1:0] aw_addr;
  logic w_got;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic next_aw_got;
  logic next_w_got;
  logic next_bvalid;
  logic ar_take;
  logic next_rvalid;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // register index 0..6, 7 means unmapped or misaligned
  function automatic logic [2:0] reg_index(input logic [`TAD_ADDR_BITS-1:0] addr);
    logic [2:0] idx;
    idx = 3'h7;
    case (addr)
      `TAD_OFS_CMD: idx = 3'h0;
      `TAD_OFS_CFG: idx = 3'h1;
      `TAD_OFS_NEW_DATA: idx = 3'h2;
      `TAD_OFS_STATUS: idx = 3'h3;
      `TAD_OFS_RESULT: idx = 3'h4;
      `TAD_OFS_VIEW_SEL: idx = 3'h5;
      `TAD_OFS_VIEW_DATA: idx = 3'h6;
      default: idx = 3'h7;
    endcase
    return idx;
  endfunction : reg_index

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val, input logic [31:0] val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int k = 0; k < 4; k++)
    begin
      if (strb[k])
        res[k*8 +: 8] = val[k*8 +: 8];
    end
    return res;
  endfunction : merge_bytes

  // combinational read of any working register, used for operands and view
  function automatic logic [31:0] work_word(input logic [3:0] sel);
    logic [31:0] res;
    res = `TAD_WORD_RESET;
    if (sel[3] == 1'b0)
      res = reg_file[sel[2:0]]; // [RULE18]
    else if (sel == `TAD_VIEW_A)
      res = work_a;
    else if (sel == `TAD_VIEW_B)
      res = work_b;
    else if (sel == `TAD_VIEW_C)
      res = work_c;
    return res;
  endfunction : work_word

  // ----------------------------------------------------------------
  // command fields
  // ----------------------------------------------------------------
  logic [3:0] function_select;
  logic logic_mode;
  logic cmd_cin;
  logic shift_code_bit0;
  logic shift_code_bit1;
  logic [2:0] src_a;
  logic [2:0] src_b;
  logic [2:0] dst;
  logic double_len;
  logic single_addr;
  logic fill_bit;

  assign function_select = cmd_word[`TAD_CMD_SEL_LSB +: 4];
  assign logic_mode = cmd_word[`TAD_CMD_LOGIC_BIT];
  assign cmd_cin = cmd_word[`TAD_CMD_CIN_BIT];
  assign shift_code_bit0 = cmd_word[`TAD_CMD_SHIFT_LSB];
  assign shift_code_bit1 = cmd_word[`TAD_CMD_SHIFT_LSB + 1];
  assign src_a = cmd_word[`TAD_CMD_SRC_A_LSB +: 3];
  assign src_b = cmd_word[`TAD_CMD_SRC_B_LSB +: 3];
  assign dst = cmd_word[`TAD_CMD_DST_LSB +: 3];
  assign double_len = cmd_word[`TAD_CMD_DOUBLE_BIT];
  assign single_addr = cmd_word[`TAD_CMD_SINGLE_BIT];
  assign fill_bit = cmd_word[`TAD_CMD_FILL_BIT];

  // ----------------------------------------------------------------
  // operand selection
  // ----------------------------------------------------------------
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [2:0] dst_low;

  // single-address: A is always one side, B or C the other
  assign op_a = single_addr ? work_a : work_word({1'b0, src_a}); // [RULE13] [RULE15]
  assign op_b = single_addr ? (src_b[1] ? work_c : work_b) : work_word({1'b0, src_b}); // [RULE13] [RULE15]
  // low half of a double-length pair is the next address up, wrapping
  assign dst_low = 3'(dst + 3'h1); // [RULE16]

  // ----------------------------------------------------------------
  // slice array with ripple or block lookahead carry
  // ----------------------------------------------------------------
  logic [31:0] alu_f;
  logic [NUM_SLICES-1:0] sl_cin;
  logic [NUM_SLICES-1:0] sl_cout;
  logic [NUM_SLICES-1:0] sl_gen;
  logic [NUM_SLICES-1:0] sl_prop;
  logic [NUM_SLICES-1:0] sl_ones;
  logic [NUM_BLOCKS*3-1:0] lah_carry;
  logic [NUM_BLOCKS-1:0] blk_gen;
  logic [NUM_BLOCKS-1:0] blk_prop;
  logic [NUM_BLOCKS:0] blk_cin;
  logic alu_cout;
  logic alu_equal;

  assign blk_cin[0] = cmd_cin;

  genvar s;
  generate
    for (s = 0; s < NUM_SLICES; s = s + 1)
    begin : g_slice
      if (s == 0)
      begin : g_first
        assign sl_cin[s] = cmd_cin;
      end
      else if ((s % PER_BLOCK) == 0)
      begin : g_block_head
        // block heads take the rippled block carry in lookahead mode
        assign sl_cin[s] = cfg_lookahead ? blk_cin[s / PER_BLOCK] : sl_cout[s - 1]; // [RULE1] [RULE4]
      end
      else
      begin : g_inner
        assign sl_cin[s] = cfg_lookahead ? lah_carry[(s / PER_BLOCK) * 3 + (s % PER_BLOCK) - 1]
          : sl_cout[s - 1]; // [RULE1] [RULE5]
      end
      tad_alu_slice u_slice (
        .operand_a(op_a[s*4 +: 4]),
        .operand_b(op_b[s*4 +: 4]),
        .function_select(function_select),
        .logic_mode(logic_mode),
        .carry_in(sl_cin[s]),
        .result(alu_f[s*4 +: 4]),
        .slice_carry_output(sl_cout[s]),
        .group_generate(sl_gen[s]),
        .group_propagate(sl_prop[s]),
        .all_ones(sl_ones[s])
      );
    end
    // one lookahead unit per 16-bit block, two levels at most at this width
    for (s = 0; s < NUM_BLOCKS; s = s + 1)
    begin : g_block
      tad_lookahead u_lookahead (
        .generate_in(sl_gen[s*PER_BLOCK +: PER_BLOCK]),
        .propagate_in(sl_prop[s*PER_BLOCK +: PER_BLOCK]),
        .carry_in(blk_cin[s]),
        .carry_out(lah_carry[s*3 +: 3]),
        .block_generate(blk_gen[s]),
        .block_propagate(blk_prop[s])
      ); // [RULE5] [RULE6] [RULE7] [RULE8]
      // carry ripples from one block into the next
      assign blk_cin[s + 1] = blk_gen[s] | (blk_prop[s] & blk_cin[s]); // [RULE4] [RULE7]
    end
  endgenerate

  // carry-out doubles as unsigned magnitude flag during subtraction
  assign alu_cout = cfg_lookahead ? blk_cin[NUM_BLOCKS] : sl_cout[NUM_SLICES-1]; // [RULE11]
  // zero on pass, complementary on xor, equal on equivalence
  assign alu_equal = &sl_ones; // [RULE9] [RULE10]

  // ----------------------------------------------------------------
  // loop multiplexer between alu and register write port
  // ----------------------------------------------------------------
  logic [31:0] low_old;
  logic [31:0] next_high;
  logic [31:0] next_low;

  assign low_old = single_addr ? work_b : reg_file[dst_low];

  always_comb
  begin
    next_high = alu_f;
    next_low = low_old;
    case (tad_pkg::tad_shift_type'({shift_code_bit1, shift_code_bit0}))
      tad_pkg::tad_sh_load: next_high = new_data; // [RULE17]
      tad_pkg::tad_sh_pass: next_high = alu_f; // [RULE17]
      tad_pkg::tad_sh_left:
      begin
        next_high = {alu_f[30:0], double_len ? low_old[31] : fill_bit}; // [RULE17] [RULE16]
        next_low = {low_old[30:0], fill_bit};
      end
      tad_pkg::tad_sh_right:
      begin
        next_high = {fill_bit, alu_f[31:1]}; // [RULE17]
        next_low = {alu_f[0], low_old[31:1]}; // [RULE16]
      end
      default: next_high = alu_f;
    endcase
  end

  // ----------------------------------------------------------------
  // microcycle sequencing: a command write launches one exec cycle
  // ----------------------------------------------------------------
  logic cmd_launch;

  assign cmd_launch = do_write && (reg_index(aw_addr) == 3'h0);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      state <= tad_pkg::tad_st_idle;
    else
      case (state)
        tad_pkg::tad_st_idle: state <= cmd_launch ? tad_pkg::tad_st_exec : tad_pkg::tad_st_idle;
        tad_pkg::tad_st_exec: state <= tad_pkg::tad_st_idle;
        default: state <= tad_pkg::tad_st_idle;
      endcase
  end

  // destination write at the end of the exec cycle
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      for (int r = 0; r < `TAD_NUM_REGS; r++)
        reg_file[r] <= `TAD_WORD_RESET;
    end
    else if (state == tad_pkg::tad_st_exec && !single_addr)
    begin
      reg_file[dst] <= next_high; // [RULE14] [RULE15] [RULE18]
      if (double_len)
        reg_file[dst_low] <= next_low; // [RULE16]
    end
  end

  // single-address working registers; double length pairs A over B
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      work_a <= `TAD_WORD_RESET;
      work_b <= `TAD_WORD_RESET;
      work_c <= `TAD_WORD_RESET;
    end
    else if (state == tad_pkg::tad_st_exec && single_addr)
    begin
      if (double_len)
      begin
        work_a <= next_high; // [RULE13] [RULE16]
        work_b <= next_low;
      end
      else if (dst[1])
        work_c <= next_high; // [RULE13]
      else if (dst[0])
        work_b <= next_high;
      else
        work_a <= next_high;
    end
  end

  // flags captured with the result for software to inspect
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      result_word <= `TAD_WORD_RESET;
      flag_equal <= 1'b0;
      flag_carry <= 1'b0;
      flag_gen <= 1'b0;
      flag_prop <= 1'b0;
    end
    else if (state == tad_pkg::tad_st_exec)
    begin
      result_word <= alu_f;
      flag_equal <= alu_equal; // [RULE9]
      flag_carry <= alu_cout; // [RULE11]
      flag_gen <= blk_gen[NUM_BLOCKS-1];
      flag_prop <= blk_prop[NUM_BLOCKS-1];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel: address and data in either order
  // ----------------------------------------------------------------
  always_comb
  begin
    do_write = aw_got && w_got && !s_axi_bvalid;
    next_aw_got = do_write ? 1'b0 : (aw_got || (s_axi_awvalid && s_axi_awready));
    next_w_got = do_write ? 1'b0 : (w_got || (s_axi_wvalid && s_axi_wready));
    next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= `TAD_WORD_RESET;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TAD_RESP_OKAY;
    end
    else
    begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      if (s_axi_awvalid && s_axi_awready)
        aw_addr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // one write at a time: ready stays low until the response is taken
      s_axi_awready <= !next_aw_got && !next_bvalid;
      s_axi_wready <= !next_w_got && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (do_write)
        s_axi_bresp <= (reg_index(aw_addr) == 3'h7) ? `TAD_RESP_SLVERR : `TAD_RESP_OKAY;
    end
  end

  // writable registers; status, result and view data are read-only
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cmd_word <= `TAD_WORD_RESET;
      cfg_lookahead <= 1'b0;
      new_data <= `TAD_WORD_RESET;
      view_sel <= 4'h0;
    end
    else if (do_write)
      case (reg_index(aw_addr))
        3'h0: cmd_word <= merge_bytes(cmd_word, w_data, w_strb);
        3'h1: cfg_lookahead <= w_strb[0] ? w_data[0] : cfg_lookahead;
        3'h2: new_data <= merge_bytes(new_data, w_data, w_strb);
        3'h5: view_sel <= w_strb[0] ? w_data[3:0] : view_sel;
        default: view_sel <= view_sel;
      endcase
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel: data one edge after the address is taken
  // ----------------------------------------------------------------
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `TAD_WORD_RESET;
      s_axi_rresp <= `TAD_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take)
      begin
        s_axi_rresp <= `TAD_RESP_OKAY;
        case (reg_index(s_axi_araddr))
          3'h0: s_axi_rdata <= cmd_word;
          3'h1: s_axi_rdata <= {31'h00000000, cfg_lookahead};
          3'h2: s_axi_rdata <= new_data;
          3'h3: s_axi_rdata <= {27'h0000000, flag_prop, flag_gen, flag_carry, flag_equal,
                                state == tad_pkg::tad_st_exec};
          3'h4: s_axi_rdata <= result_word;
          3'h5: s_axi_rdata <= {28'h0000000, view_sel};
          3'h6: s_axi_rdata <= work_word(view_sel);
          default:
          begin
            s_axi_rdata <= `TAD_WORD_RESET;
            s_axi_rresp <= `TAD_RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule : tad_datapath

// [rtl/tad_lookahead.sv]
module tad_lookahead (
  input logic [3:0] generate_in,
  input logic [3:0] propagate_in,
  input logic carry_in,
  output logic [2:0] carry_out,
  output logic block_generate,
  output logic block_propagate
);

  // ----------------------------------------------------------------
  // four gen/prop pairs give three slice carries and a next-level pair
  // ----------------------------------------------------------------
  logic [3:0] g;
  logic [3:0] p;

  assign g = generate_in;
  assign p = propagate_in;
  assign carry_out[0] = g[0] | (p[0] & carry_in); // [RULE3]
  assign carry_out[1] = g[1] | (p[1] & g[0]) | (&p[1:0] & carry_in); // [RULE3]
  assign carry_out[2] = g[2] | (p[2] & g[1]) | (&p[2:1] & g[0]) | (&p[2:0] & carry_in); // [RULE3]
  assign block_generate = g[3] | (p[3] & g[2]) | (&p[3:2] & g[1]) | (&p[3:1] & g[0]); // [RULE3]
  assign block_propagate = &p; // [RULE3]

endmodule : tad_lookahead

// [rtl/tad_pkg.sv]
package tad_pkg;

  // ----------------------------------------------------------------
  // sequencing and loop multiplexer codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    tad_st_idle = 2'b01,
    tad_st_exec = 2'b10
  } tad_state_type;

  // index is {shift_code_bit1, shift_code_bit0}
  typedef enum logic [1:0] {
    tad_sh_load = 2'b00,
    tad_sh_pass = 2'b01,
    tad_sh_left = 2'b10,
    tad_sh_right = 2'b11
  } tad_shift_type;

endpackage : tad_pkg

// [rtl/tad_regs.svh]
`ifndef TAD_REGS_SVH
`define TAD_REGS_SVH

// ----------------------------------------------------------------
// datapath geometry
// ----------------------------------------------------------------
`define TAD_WORD_BITS 32
`define TAD_SLICE_BITS 4
`define TAD_NUM_SLICES 8
`define TAD_BLOCK_BITS 16
`define TAD_SLICES_PER_BLOCK 4
`define TAD_NUM_REGS 8
`define TAD_ADDR_BITS 5

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TAD_OFS_CMD 5'h00
`define TAD_OFS_CFG 5'h04
`define TAD_OFS_NEW_DATA 5'h08
`define TAD_OFS_STATUS 5'h0C
`define TAD_OFS_RESULT 5'h10
`define TAD_OFS_VIEW_SEL 5'h14
`define TAD_OFS_VIEW_DATA 5'h18

// ----------------------------------------------------------------
// command word fields (lsb positions)
// ----------------------------------------------------------------
`define TAD_CMD_SEL_LSB 0
`define TAD_CMD_LOGIC_BIT 4
`define TAD_CMD_CIN_BIT 5
`define TAD_CMD_SHIFT_LSB 6
`define TAD_CMD_SRC_A_LSB 8
`define TAD_CMD_SRC_B_LSB 11
`define TAD_CMD_DST_LSB 14
`define TAD_CMD_DOUBLE_BIT 17
`define TAD_CMD_SINGLE_BIT 18
`define TAD_CMD_FILL_BIT 19

// ----------------------------------------------------------------
// status bits, view codes, responses, reset values
// ----------------------------------------------------------------
`define TAD_STAT_BUSY_BIT 0
`define TAD_STAT_EQUAL_BIT 1
`define TAD_STAT_CARRY_BIT 2
`define TAD_STAT_GEN_BIT 3
`define TAD_STAT_PROP_BIT 4
`define TAD_VIEW_A 4'h8
`define TAD_VIEW_B 4'h9
`define TAD_VIEW_C 4'hA
`define TAD_RESP_OKAY 2'h0
`define TAD_RESP_SLVERR 2'h2
`define TAD_WORD_RESET 32'h00000000

`endif

// [testbench/tad_datapath_monitor.sv]
// ----------
// bus timing checker
// ----------
module tad_datapath_monitor (
  input logic sys_clk,
  input logic srst,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [4:0] s_axi_araddr,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // both write halves taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // beyond the last word or off a word boundary
  sequence s_bad_addr;
    s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > 5'h18;
  endsequence
  chk_wr_answer: assert property (s_wr_take |=> ##[0:1] s_axi_bvalid)
    else $error("no write response");
  chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("no read response");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response lost");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data lost");
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_bad_read: assert property (s_rd_take ##0 s_bad_addr |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("bad read answered");
  chk_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("response repeated");
  // reset is the trigger, so it cannot disable
  chk_reset_idle: assert property (disable iff (1'b0) srst |=> !s_axi_bvalid && !s_axi_rvalid && !s_axi_arready)
    else $error("busy after reset");
endmodule : tad_datapath_monitor

bind tad_datapath tad_datapath_monitor u_mon (.*);

// [testbench/tad_seq_model.sv]
// ----------
// control sequencer, bus master side
// ----------
module tad_seq_model (
  input logic sys_clk,
  output logic awvalid,
  input logic awready,
  output logic [4:0] awaddr,
  output logic wvalid,
  input logic wready,
  output logic [31:0] wdata,
  input logic bvalid,
  output logic bready,
  input logic [1:0] bresp,
  output logic arvalid,
  input logic arready,
  output logic [4:0] araddr,
  input logic rvalid,
  output logic rready,
  input logic [31:0] rdata,
  input logic [1:0] rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
  // microinstruction word, mode is {fill, single, double}
  function automatic logic [31:0] mk(logic [7:0] lo, logic [2:0] a, logic [2:0] b, logic [2:0] d, logic [2:0] m);
    return {12'h000, m, d, b, a, lo};
  endfunction : mk
  // one line picks add or pass
  function automatic logic [3:0] ap(logic s);
    return {s, 1'b0, 1'b0, s};
  endfunction : ap
  task automatic to();
    tb.err_total++;
    tb.end_sim();
  endtask : to
  // released payload is inverted so a stale value is never read as fresh
  task automatic wr(logic [4:0] a, logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    {awvalid, wvalid, bready, awaddr, wdata} <= {3'h7, a, d};
    repeat (40)
    begin
      @(posedge sys_clk);
      if (awready) {awvalid, awaddr} <= {1'b0, ~a};
      if (wready) {wvalid, wdata} <= {1'b0, ~d};
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (!bvalid) to();
  endtask : wr
  task automatic rd(logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    {arvalid, rready, araddr} <= {2'h3, a};
    repeat (40)
    begin
      @(posedge sys_clk);
      if (arready) {arvalid, araddr} <= {1'b0, ~a};
      if (rvalid) break;
    end
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
    if (!rvalid) to();
  endtask : rd
endmodule : tad_seq_model

// [testbench/tb.sv]
// ----------
// datapath bench
// ----------
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] c; logic [31:0] nd; logic [3:0] v; logic [31:0] e; logic [1:0] m;
    logic [1:0] f;} tad_row_type;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [1:0] bresp, rresp, resp;
  int err_total = 0;
  int check_count = 0;
  tad_row_type rows [15];
  tad_datapath DUT (.sys_clk, .srst, .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  tad_seq_model seq (.*);
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic cmp(logic [33:0] g, logic [33:0] x);
    check_count++;
    if (g !== x)
    begin
      err_total++;
      $display("mismatch %0t got %h exp %h", $time, g, x);
    end
  endtask : cmp
  // every read must also answer okay
  task automatic rdc(logic [4:0] a, logic [31:0] e);
    seq.rd(a, rd_val, resp);
    cmp({resp, rd_val}, {2'h0, e});
  endtask : rdc
  task automatic end_sim();
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // rows: command, new data, view, expected view, flag mask, flags {carry, equal}
  initial
  begin
    rows = '{
      '{seq.mk(8'h00, 3'h0, 3'h0, 3'h1, 3'h0), 32'hFFFF, 4'h1, 32'hFFFF, 2'h0, 2'h0},
      '{seq.mk(8'h00, 3'h0, 3'h0, 3'h2, 3'h0), 32'h1, 4'h2, 32'h1, 2'h0, 2'h0},
      '{seq.mk({4'h4, seq.ap(1'b1)}, 3'h1, 3'h2, 3'h3, 3'h0), 32'h0, 4'h3, 32'h10000, 2'h3, 2'h0},
      '{seq.mk(8'h66, 3'h1, 3'h2, 3'h4, 3'h0), 32'h0, 4'h4, 32'hFFFE, 2'h3, 2'h2},
      '{seq.mk(8'h66, 3'h2, 3'h1, 3'h5, 3'h0), 32'h0, 4'h5, 32'hFFFF0002, 2'h3, 2'h0},
      '{seq.mk(8'h56, 3'h1, 3'h2, 3'h6, 3'h0), 32'h0, 4'h6, 32'hFFFE, 2'h1, 2'h0},
      '{seq.mk(8'h59, 3'h1, 3'h1, 3'h7, 3'h0), 32'h0, 4'h7, 32'hFFFFFFFF, 2'h1, 2'h1},
      '{seq.mk(8'h50, 3'h0, 3'h0, 3'h6, 3'h0), 32'h0, 4'h6, 32'hFFFFFFFF, 2'h1, 2'h1},
      '{seq.mk(8'h49, 3'h6, 3'h2, 3'h5, 3'h0), 32'h0, 4'h5, 32'h0, 2'h3, 2'h2},
      '{seq.mk(8'h80, 3'h1, 3'h0, 3'h4, 3'h0), 32'h0, 4'h4, 32'h1FFFE, 2'h0, 2'h0},
      '{seq.mk(8'hC0, 3'h1, 3'h0, 3'h3, 3'h0), 32'h0, 4'h3, 32'h7FFF, 2'h0, 2'h0},
      '{seq.mk({4'h4, seq.ap(1'b0)}, 3'h1, 3'h0, 3'h2, 3'h0), 32'h0, 4'h2, 32'hFFFF, 2'h3, 2'h0},
      '{seq.mk(8'h00, 3'h0, 3'h0, 3'h0, 3'h2), 32'h5, 4'h8, 32'h5, 2'h0, 2'h0},
      '{seq.mk(8'h00, 3'h0, 3'h0, 3'h2, 3'h2), 32'h12345678, 4'hA, 32'h12345678, 2'h0, 2'h0},
      '{seq.mk(8'h49, 3'h0, 3'h2, 3'h0, 3'h2), 32'h0, 4'h8, 32'h1234567D, 2'h3, 2'h0}
    };
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    rdc(5'h0C, 32'h0);
    rdc(5'h10, 32'h0);
    // ripple pass, then lookahead pass, same results
    for (int p = 0; p < 2; p++)
    begin
      seq.wr(5'h04, 32'(p), resp);
      foreach (rows[i])
      begin
        seq.wr(5'h08, rows[i].nd, resp);
        seq.wr(5'h00, rows[i].c, resp);
        seq.wr(5'h14, {28'h0, rows[i].v}, resp);
        rdc(5'h18, rows[i].e);
        seq.rd(5'h0C, rd_val, resp);
        cmp({32'h0, rd_val[2:1] & rows[i].m}, {32'h0, rows[i].f & rows[i].m});
      end
    end
    // double length left shift, low half wraps into register 0
    seq.wr(5'h00, seq.mk(8'h80, 3'h1, 3'h0, 3'h7, 3'h5), resp);
    seq.wr(5'h14, 32'h7, resp);
    rdc(5'h18, 32'h1FFFE);
    seq.wr(5'h14, 32'h0, resp);
    rdc(5'h18, 32'h1);
    seq.rd(5'h1C, rd_val, resp);
    cmp({resp, rd_val}, {2'h2, 32'h0});
    seq.wr(5'h02, 32'h1, resp);
    cmp({32'h0, resp}, {32'h0, 2'h2});
    // second reset must clear the file
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    seq.wr(5'h14, 32'h1, resp);
    rdc(5'h18, 32'h0);
    end_sim();
  end
endmodule : tb
